// ===== rtl/mss_sequencer.v
`timescale 1ns/1ps
`include "mss_regs.vh"

// Notes on behaviour
// - A 64-word by 32-bit program store is addressed by the sequencer and feeds a pipeline register.
// - Seven condition inputs are accepted and sixteen control outputs come from the pipeline.
// - Condition-select code 110 in bits 24 to 22 tests the dedicated condition input.
// - With diagnostics enabled the condition input is also the serial shift data input.
// - Counter, loop count, return register, pipeline and match flag all update on each rising edge.
// - The upper eight outputs are always driven from the pipeline; the output-enable bit only drives ctrl_hi_oe_out.
// - A tester can shift a microinstruction in, have it executed, and shift the results out.
// - Jumps, loops, calls and multiway branches each execute only when the selected test holds.
// - Reset forces next address 63, loads it and its word, and clears the match flag.
// - The lower eight control outputs are always driven.
// - The zero output is low whenever the loop count register holds zero.
// - The six test inputs serve as conditions, as a branch target, or as a count value.
module mss_sequencer #(
    parameter [4:0] OPC_CONT = 5'h00,
    parameter [4:0] OPC_JMP = 5'h01,
    parameter [4:0] OPC_JMP_T = 5'h02,
    parameter [4:0] OPC_CALL = 5'h03,
    parameter [4:0] OPC_RET = 5'h04,
    parameter [4:0] OPC_LDCT = 5'h05,
    parameter [4:0] OPC_LDCT_T = 5'h06,
    parameter [4:0] OPC_LOOP = 5'h07,
    parameter [4:0] OPC_WAIT = 5'h08,
    parameter [4:0] OPC_CMP = 5'h09,
    parameter [4:0] OPC_DECCT = 5'h0A,
    parameter [4:0] OPC_CALL_T = 5'h0B
) (
    input wire clock_in,
    input wire sys_rst_in,
    input wire [5:0] test_in,
    input wire condition_input_in,
    input wire diag_enable_in,
    input wire diag_shift_clock_in,
    input wire diag_mode_in,
    input wire prog_we_in,
    input wire [5:0] prog_addr_in,
    input wire [31:0] prog_data_in,
    output wire [7:0] ctrl_lo_out,
    output wire [7:0] ctrl_hi_out,
    output wire ctrl_hi_oe_out,
    output wire zero_n_out,
    output wire serial_shift_output_out,
    output wire [5:0] pc_out
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg [5:0] test_s1_q;
    reg [5:0] test_q;
    reg cond_s1_q;
    reg cond_q;
    reg shclk_s1_q;
    reg shclk_q;
    reg shclk_dly_q;
    reg mode_s1_q;
    reg mode_q;

    always @(posedge clock_in) begin
        test_s1_q <= test_in;
        test_q <= test_s1_q;
        cond_s1_q <= condition_input_in;
        cond_q <= cond_s1_q;
        shclk_s1_q <= diag_shift_clock_in;
        shclk_q <= shclk_s1_q;
        shclk_dly_q <= shclk_q;
        mode_s1_q <= diag_mode_in;
        mode_q <= mode_s1_q;
    end

    wire shclk_rise = diag_enable_in & shclk_q & ~shclk_dly_q;
    wire shift_pulse = shclk_rise & mode_q;
    wire exec_pulse = shclk_rise & ~mode_q;

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    reg [5:0] pc_q;
    reg [5:0] pc_d;
    reg [31:0] pipe_q;
    reg [31:0] pipe_d;
    reg [5:0] count_q;
    reg [5:0] count_d;
    reg [5:0] sub_q;
    reg [5:0] sub_d;
    reg match_q;
    reg match_d;
    reg zero_n_q;
    reg shift_out_q;
    reg [31:0] shadow_q;
    reg [31:0] shadow_d;
    reg capture_q;

    wire [31:0] store_word;
    reg [5:0] next_addr;

    mss_prog_store #(
        .ADDR_W(`MSS_ADDR_W),
        .WORD_W(`MSS_WORD_W)
    ) u_store (
        .clock_in(clock_in),
        .prog_we_in(prog_we_in),
        .prog_addr_in(prog_addr_in),
        .prog_data_in(prog_data_in),
        .rd_addr_in(next_addr),
        .rd_data_out(store_word)
    );

    // ----------------------------------------
    // field decode
    // ----------------------------------------
    wire [4:0] opc = pipe_q[`MSS_OPC_HI:`MSS_OPC_LO];
    wire [2:0] test_sel = pipe_q[`MSS_TEST_HI:`MSS_TEST_LO];
    wire [5:0] data_f = pipe_q[`MSS_DATA_HI:`MSS_DATA_LO];
    wire pol = pipe_q[`MSS_POL_BIT];
    wire [5:0] pc_inc = pc_q + 6'h01;
    wire count_zero = (count_q == 6'h00);

    reg cond_raw;

    always @* begin
        if (test_sel == `MSS_TEST_COND_PIN) begin
            cond_raw = cond_q;
        end else if (test_sel == `MSS_TEST_MATCH) begin
            cond_raw = match_q;
        end else begin
            cond_raw = test_q[test_sel];
        end
    end

    // polarity bit lets a test fire on either level
    wire cond = cond_raw ^ pol;

    // ----------------------------------------
    // next address selector and register update
    // ----------------------------------------
    always @* begin
        next_addr = pc_inc;
        count_d = count_q;
        sub_d = sub_q;
        match_d = match_q;
        case (opc)
            OPC_CONT: begin
                next_addr = pc_inc;
            end
            OPC_JMP: begin
                if (cond) begin
                    next_addr = data_f;
                end
            end
            OPC_JMP_T: begin
                if (cond) begin
                    next_addr = test_q;
                end
            end
            OPC_CALL: begin
                if (cond) begin
                    next_addr = data_f;
                    sub_d = pc_inc;
                end
            end
            OPC_CALL_T: begin
                if (cond) begin
                    next_addr = test_q;
                    sub_d = pc_inc;
                end
            end
            OPC_RET: begin
                if (cond) begin
                    next_addr = sub_q;
                end
            end
            OPC_LDCT: begin
                if (cond) begin
                    count_d = data_f;
                end
            end
            OPC_LDCT_T: begin
                if (cond) begin
                    count_d = test_q;
                end
            end
            OPC_LOOP: begin
                if (cond && !count_zero) begin
                    count_d = count_q - 6'h01;
                    next_addr = data_f;
                end
            end
            OPC_WAIT: begin
                if (!cond) begin
                    next_addr = pc_q;
                end
            end
            OPC_CMP: begin
                if (cond) begin
                    match_d = (test_q == data_f);
                end
            end
            OPC_DECCT: begin
                if (cond && !count_zero) begin
                    count_d = count_q - 6'h01;
                end
            end
            default: begin
                next_addr = pc_inc;
            end
        endcase
        if (sys_rst_in) begin
            next_addr = `MSS_RESET_ADDR;
        end
    end

    always @* begin
        pc_d = next_addr;
        // an executed shadow word takes the place of the fetched word
        if (exec_pulse && !sys_rst_in) begin
            pipe_d = shadow_q;
        end else begin
            pipe_d = store_word;
        end
    end

    // ----------------------------------------
    // serial shadow path
    // ----------------------------------------
    always @* begin
        shadow_d = shadow_q;
        if (shift_pulse) begin
            shadow_d = {shadow_q[30:0], cond_q};
        end else if (capture_q) begin
            // result snapshot in the cycle the shadow word runs, one cycle after the execute pulse
            shadow_d = {pc_q, count_q, match_q, 3'h0, pipe_q[15:0]};
        end
    end

    always @(posedge clock_in) begin
        pc_q <= pc_d;
        pipe_q <= pipe_d;
        if (sys_rst_in) begin
            match_q <= 1'b0;
            count_q <= `MSS_COUNT_RST;
            sub_q <= `MSS_RESET_ADDR;
            zero_n_q <= 1'b0;
            shift_out_q <= 1'b0;
            shadow_q <= `MSS_SHADOW_RST;
            capture_q <= 1'b0;
        end else begin
            match_q <= match_d;
            count_q <= count_d;
            sub_q <= sub_d;
            zero_n_q <= (count_d != 6'h00);
            shadow_q <= shadow_d;
            capture_q <= exec_pulse;
            // pin is shared; internal zero detect is unchanged
            shift_out_q <= diag_enable_in ? shadow_d[31] : (count_d != 6'h00);
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign ctrl_lo_out = pipe_q[7:0];
    assign ctrl_hi_out = pipe_q[`MSS_CTRL_HI:8];
    assign ctrl_hi_oe_out = pipe_q[`MSS_OE_BIT];
    assign zero_n_out = zero_n_q;
    assign serial_shift_output_out = shift_out_q;
    assign pc_out = pc_q;

endmodule // mss_sequencer

// ===== rtl/mss_regs.vh
`ifndef MSS_REGS_VH
`define MSS_REGS_VH

// ----------------------------------------
// program store geometry
// ----------------------------------------
`define MSS_ADDR_W 6
`define MSS_WORD_W 32
`define MSS_RESET_ADDR 6'h3F

// ----------------------------------------
// microinstruction field positions
// ----------------------------------------
`define MSS_OE_BIT 31
`define MSS_POL_BIT 30
`define MSS_OPC_HI 29
`define MSS_OPC_LO 25
`define MSS_TEST_HI 24
`define MSS_TEST_LO 22
`define MSS_DATA_HI 21
`define MSS_DATA_LO 16
`define MSS_CTRL_HI 15
`define MSS_CTRL_LO 0

// ----------------------------------------
// condition select codes
// ----------------------------------------
`define MSS_TEST_COND_PIN 3'h6
`define MSS_TEST_MATCH 3'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define MSS_COUNT_RST 6'h00
`define MSS_SHADOW_RST 32'h00000000

`endif

// ===== rtl/mss_prog_store.v
`timescale 1ns/1ps
`include "mss_regs.vh"

// ----------------------------------------
// 64 x 32 program store, asynchronous read
// ----------------------------------------
module mss_prog_store #(
    parameter ADDR_W = `MSS_ADDR_W,
    parameter WORD_W = `MSS_WORD_W
) (
    input wire clock_in,
    input wire prog_we_in,
    input wire [ADDR_W-1:0] prog_addr_in,
    input wire [WORD_W-1:0] prog_data_in,
    input wire [ADDR_W-1:0] rd_addr_in,
    output wire [WORD_W-1:0] rd_data_out
);

    reg [WORD_W-1:0] mem_q [0:(1<<ADDR_W)-1];

    // programming port stands in for fuse programming
    always @(posedge clock_in) begin
        if (prog_we_in) begin
            mem_q[prog_addr_in] <= prog_data_in;
        end
    end

    assign rd_data_out = mem_q[rd_addr_in];

endmodule // mss_prog_store

// ===== dv/mss_seq_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the sequencer
// ----------------------------------------
module mss_seq_chk #(
    parameter [4:0] OPC_CONT = 5'h00,
    parameter [4:0] OPC_JMP = 5'h01,
    parameter [4:0] OPC_CALL = 5'h03,
    parameter [4:0] OPC_RET = 5'h04,
    parameter [4:0] OPC_LDCT = 5'h05
) (
    input wire clock_in,
    input wire sys_rst_in,
    input wire condition_input_in,
    input wire diag_enable_in,
    input wire prog_we_in,
    input wire [5:0] prog_addr_in,
    input wire [31:0] prog_data_in,
    input wire [7:0] ctrl_lo_out,
    input wire ctrl_hi_oe_out,
    input wire zero_n_out,
    input wire serial_shift_output_out,
    input wire [5:0] pc_out
);
    // store mirror; only valid while the store is written under reset
    reg [31:0] mem_q [0:63];
    reg [2:0] pin_hist_q;
    reg dg_q;
    wire [31:0] w = mem_q[pc_out];
    wire [4:0] opc = w[29:25];
    wire [5:0] dat = w[21:16];
    wire cnd = condition_input_in ^ w[30];
    wire run = !diag_enable_in && !dg_q;
    // pin steady 3 cycles, so the synced copy equals it
    wire ccs = run && pin_hist_q == {3{condition_input_in}} && w[24:22] == 3'h6;
    always @(posedge clock_in) begin
        if (prog_we_in) begin
            mem_q[prog_addr_in] <= prog_data_in;
        end
        pin_hist_q <= {pin_hist_q[1:0], condition_input_in};
        dg_q <= diag_enable_in;
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_call_ret;
        ccs && cnd && opc == OPC_CALL ##1 ccs && cnd && opc == OPC_RET;
    endsequence
    a_reset_load: assert property (disable iff (1'b0) sys_rst_in && !prog_we_in |=>
        pc_out == 6'h3F && ctrl_lo_out === mem_q[63][7:0] && !zero_n_out)
        else $error("reset load wrong");
    a_lo_fetch: assert property (run |-> ctrl_lo_out === w[7:0])
        else $error("lower outputs wrong");
    a_oe_bit: assert property (run |-> ctrl_hi_oe_out === w[31])
        else $error("enable bit wrong");
    a_cont_step: assert property (run && opc == OPC_CONT |=> pc_out == $past(pc_out) + 6'h01)
        else $error("continue step wrong");
    a_jmp_cc: assert property (ccs && opc == OPC_JMP |=>
        pc_out == ($past(cnd) ? $past(dat) : $past(pc_out) + 6'h01))
        else $error("conditional jump wrong");
    a_ldct_zero: assert property (ccs && cnd && opc == OPC_LDCT |=>
        zero_n_out == ($past(dat) != 6'h00))
        else $error("zero output wrong");
    a_call_ret: assert property (s_call_ret |=> pc_out == $past(pc_out, 2) + 6'h01)
        else $error("return address wrong");
    a_sdo_copy: assert property (run && $stable(zero_n_out) |->
        serial_shift_output_out == zero_n_out)
        else $error("serial out copy wrong");
endmodule // mss_seq_chk

bind mss_sequencer mss_seq_chk #(.OPC_CONT(OPC_CONT), .OPC_JMP(OPC_JMP), .OPC_CALL(OPC_CALL),
    .OPC_RET(OPC_RET), .OPC_LDCT(OPC_LDCT)) chk (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .condition_input_in(condition_input_in),
    .diag_enable_in(diag_enable_in), .prog_we_in(prog_we_in), .prog_addr_in(prog_addr_in),
    .prog_data_in(prog_data_in), .ctrl_lo_out(ctrl_lo_out), .ctrl_hi_oe_out(ctrl_hi_oe_out),
    .zero_n_out(zero_n_out), .serial_shift_output_out(serial_shift_output_out),
    .pc_out(pc_out));

// ===== dv/mss_sys_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// system side: feeds conditions, sees upper outputs
// ----------------------------------------
module mss_sys_model (
    input wire clock_in,
    input wire slow_in,
    input wire [5:0] test_set_in,
    input wire cond_set_in,
    input wire [7:0] ctrl_hi_in,
    input wire ctrl_hi_oe_in,
    output reg [5:0] test_out = 6'h00,
    output reg condition_out = 1'b0,
    output wire [7:0] hi_bus_out
);
    reg [5:0] t_q = 6'h00;
    reg c_q = 1'b0;
    reg [7:0] last_q = 8'h00;
    // no pull on these lines: released shows inverse of last level
    assign hi_bus_out = ctrl_hi_oe_in ? ctrl_hi_in : ~last_q;
    always @(posedge clock_in) begin
        t_q <= test_set_in;
        c_q <= cond_set_in;
        // slow adds one cycle of logic delay
        test_out <= slow_in ? t_q : test_set_in;
        condition_out <= slow_in ? c_q : cond_set_in;
        if (ctrl_hi_oe_in) begin
            last_q <= ctrl_hi_in;
        end
    end
endmodule // mss_sys_model

// ===== dv/mss_sequencer_tb.sv
`timescale 1ns/1ps
module mss_sequencer_tb;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic de = 1'b0, dk = 1'b0, dm = 1'b1, we = 1'b0, cs = 1'b1, slow = 1'b0, cv, oe, zn, shout, r;
    logic [5:0] wa = 6'h00, ts = 6'h05, tv, pc;
    logic [31:0] wd = 32'h0, res;
    logic [7:0] lo, hi, hb;
    int error_cnt = 0, compares = 0, cyc = 0;
    // expected {zero_n, pc} after each edge from reset release
    logic [6:0] trc [20] = '{7'h3F, 7'h00, 7'h41, 7'h41, 7'h01, 7'h02, 7'h0A, 7'h03, 7'h05,
        7'h06, 7'h07, 7'h14, 7'h55, 7'h56, 7'h56, 7'h56, 7'h57, 7'h58, 7'h45, 7'h46};
    always #5 clock_in = ~clock_in;
    mss_sequencer uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .test_in(tv),
        .condition_input_in(cv), .diag_enable_in(de), .diag_shift_clock_in(dk),
        .diag_mode_in(dm), .prog_we_in(we), .prog_addr_in(wa), .prog_data_in(wd),
        .ctrl_lo_out(lo), .ctrl_hi_out(hi), .ctrl_hi_oe_out(oe), .zero_n_out(zn),
        .serial_shift_output_out(shout), .pc_out(pc));
    mss_sys_model sys (.clock_in(clock_in), .slow_in(slow), .test_set_in(ts), .cond_set_in(cs),
        .ctrl_hi_in(hi), .ctrl_hi_oe_in(oe), .test_out(tv), .condition_out(cv),
        .hi_bus_out(hb));
    // ----------------------------------------
    // program and checks
    // ----------------------------------------
    function automatic [31:0] pw(input [5:0] a);
        logic [15:0] h;
        case (a)
            6'h3F: h = {2'b10, uut.OPC_JMP, 3'h6, 6'h00};
            6'h00: h = {2'b00, uut.OPC_LDCT, 3'h6, 6'h02};
            6'h01: h = {2'b10, uut.OPC_LOOP, 3'h6, 6'h01};
            6'h02: h = {2'b00, uut.OPC_CALL, 3'h6, 6'h0A};
            6'h0A: h = {2'b10, uut.OPC_RET, 3'h6, 6'h00};
            6'h03: h = {2'b00, uut.OPC_JMP_T, 3'h6, 6'h00};
            6'h05: h = {2'b10, uut.OPC_CMP, 3'h6, 6'h05};
            6'h07: h = {2'b10, uut.OPC_JMP, 3'h7, 6'h14};
            6'h14: h = {2'b00, uut.OPC_LDCT_T, 3'h6, 6'h00};
            6'h15: h = {2'b10, uut.OPC_DECCT, 3'h6, 6'h00};
            // test bit 1 is low, so this wait holds until the bench pulses it
            6'h16: h = {2'b00, uut.OPC_WAIT, 3'h1, 6'h00};
            // inverted polarity on test bit 2 makes this jump fall through
            6'h17: h = {2'b11, uut.OPC_JMP, 3'h2, 6'h28};
            6'h18: h = {2'b00, uut.OPC_CALL_T, 3'h6, 6'h00};
            default: h = {2'b00, uut.OPC_CONT, 3'h6, 6'h00};
        endcase
        pw = {h, 2'b00, a, 2'b00, a};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic t_reset;
        for (int a = 0; a < 64; a++) begin
            @(posedge clock_in);
            we <= 1'b1;
            wa <= 6'(a);
            wd <= pw(6'(a));
        end
        @(posedge clock_in);
        we <= 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
        chk("pc", 6'h3F, pc);
        chk("ctrl_lo", 8'h3F, lo);
        chk("zero_n", 1'b0, zn);
        $display("t_reset done");
    endtask
    task automatic t_flow;
        logic [31:0] w;
        @(posedge clock_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 20; i++) begin
            #1;
            w = pw(trc[i][5:0]);
            chk("pc", trc[i][5:0], pc);
            chk("zero_n", trc[i][6], zn);
            chk("ctrl_lo", w[7:0], lo);
            chk("oe", w[31], oe);
            if (w[31]) chk("hi_bus", w[15:8], hb);
            @(posedge clock_in);
            // one-cycle pulse on test bit 1 releases the wait after two held cycles
            if (i == 11) ts <= 6'h07;
            if (i == 12) ts <= 6'h05;
        end
        $display("t_flow done");
    endtask
    // one serial bit: data steady before the rise, 3 cycles to detect
    task automatic sh(input logic b, output logic o);
        cs <= b;
        repeat (5) @(posedge clock_in);
        dk <= 1'b1;
        repeat (3) @(posedge clock_in);
        #1;
        o = shout;
        repeat (2) @(posedge clock_in);
        dk <= 1'b0;
        repeat (4) @(posedge clock_in);
    endtask
    task automatic t_diag;
        logic [31:0] wv;
        wv = {2'b10, uut.OPC_CONT, 3'h6, 6'h00, 16'hC35A};
        de <= 1'b1;
        slow <= 1'b1;
        for (int i = 31; i >= 0; i--) sh(wv[i], r);
        chk("first_shift_out", wv[31], r);
        dm <= 1'b0;
        repeat (5) @(posedge clock_in);
        dk <= 1'b1;
        repeat (3) @(posedge clock_in);
        #1;
        chk("ctrl_lo", 8'h5A, lo);
        chk("hi_bus", 8'hC3, hb);
        repeat (2) @(posedge clock_in);
        dk <= 1'b0;
        dm <= 1'b1;
        repeat (6) @(posedge clock_in);
        #1;
        res[31] = shout;
        @(posedge clock_in);
        for (int i = 30; i >= 0; i--) sh(1'b0, res[i]);
        chk("res_ctrl", wv[15:0], res[15:0]);
        chk("res_match", 4'h8, res[19:16]);
        $display("t_diag done");
    endtask
    initial begin
        t_reset();
        t_flow();
        t_diag();
        give_verdict();
    end
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end
endmodule // mss_sequencer_tb
